// File: bench/rtcci_master.sv
// Two-wire bus master model that drives the clock and pulls the data line low.
// Assumes the bench resolves the open-drain data wire and clocks this model at 10 MHz.
`timescale 1ns/100ps
module rtcci_master #(
   parameter int Q = 7,
   parameter int T_LO_A = 2,
   parameter int T_LO_B = 3,
   parameter int T_HI_A = 1,
   parameter int T_HI_B = 2
) (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl_o = 1'b1,
   output logic sda_low = 1'b0
);
   // Start and stop use spans of Q clocks; a data bit takes eight clocks, 800 ns.
   // The clock stays low for five cycles because the slave answers five cycles after a fall.
   // That is faster than fast mode, so it also tests the slave's sampling margins.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   // Start, or repeated start when entered in a low clock phase.
   task automatic start();
      sda_low <= 1'b0;
      tick(Q);
      scl_o <= 1'b1;
      tick(2 * Q);
      sda_low <= 1'b1;
      tick(2 * Q);
      scl_o <= 1'b0;
      tick(Q);
   endtask : start

   // Stop: data rises while the clock is high.
   task automatic stop();
      sda_low <= 1'b1;
      tick(Q);
      scl_o <= 1'b1;
      tick(2 * Q);
      sda_low <= 1'b0;
      tick(2 * Q);
   endtask : stop

   // One bit: data moves in the low phase and is sampled mid-high.
   task automatic bit_io(input logic b, output logic s);
      sda_low <= ~b;
      tick(T_LO_B);
      scl_o <= 1'b1;
      tick(T_HI_A);
      s = sda_in;
      tick(T_HI_B);
      scl_o <= 1'b0;
      tick(T_LO_A);
   endtask : bit_io

   // A byte MSB first, then the ninth bit; mack high leaves the line released.
   task automatic xb(input logic [7:0] d, input logic mack, output logic [7:0] r,
                     output logic a);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         r[i] = s;
      end
      bit_io(mack, a);
   endtask : xb
endmodule : rtcci_master

// File: bench/rtcci_top_test.sv
// Self-checking bench: register traffic over the two-wire port with expected values.
// Assumes the master model and the design share one 10 MHz clock.
`timescale 1ns/100ps
module rtcci_top_test;
   import rtcci_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sec_tick;
   logic a1_match;
   logic a2_match;
   logic osc_stop;
   logic bad_seen;
   logic [3:0] wv;
   logic scl, m_low, sda_out, sda_oe, sda_w, stb, run, clr, pin, alt_n;
   logic [7:0] rd_addr, cal_rd, wa, wd, last_wa, last_wd;
   int err_count = 0;
   int tests_run = 0;
   int clr_n = 0;

   // The data wire is pulled up unless a party pulls it low.
   assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_low;
   // Calendar stand-in returns a value tied to the address.
   assign cal_rd = rd_addr ^ 8'h40;

   initial begin
      forever #50 clk = ~clk;
   end

   // Record calendar writes and clear pulses as they happen.
   always @(posedge clk) begin
      if (stb === 1'b1) begin
         last_wa <= wa;
         last_wd <= wd;
      end
      if (clr === 1'b1) clr_n <= clr_n + 1;
   end

   rtcci_master m_u (.clk(clk), .sda_in(sda_w), .scl_o(scl), .sda_low(m_low));

   rtcci_top dut_u (.clk(clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_pin(sda_w),
      .sda_out(sda_out), .sda_oe(sda_oe), .sec_tick(sec_tick),
      .first_alarm_match(a1_match), .second_alarm_match(a2_match),
      .osc_stopped(osc_stop), .bad_value_seen(bad_seen), .wave_1hz(wv[0]),
      .wave_4096hz(wv[1]), .wave_8192hz(wv[2]), .wave_32khz(wv[3]),
      .cal_rd_data(cal_rd), .cal_rd_addr(rd_addr), .cal_wr_stb(stb),
      .cal_wr_addr(wa), .cal_wr_data(wd), .cal_run(run), .cal_clear(clr),
      .wave_or_irq_pin(pin), .alternate_irq_pin_n(alt_n));

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // Master sends a byte and expects the slave to pull the ninth bit low.
   task automatic tx(input logic [7:0] d);
      logic [7:0] r;
      logic a;
      m_u.xb(d, 1'b1, r, a);
      chk({7'h0, a}, 8'h00);
   endtask : tx

   task automatic rx(input logic mack, output logic [7:0] r);
      logic a;
      m_u.xb(8'hff, mack, r, a);
   endtask : rx

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      m_u.start();
      tx({SLAVE_ADDR, 1'b0});
      tx(p);
      tx(d);
      m_u.stop();
   endtask : wr

   // Pointer write, repeated start, one byte read and not acknowledged.
   task automatic rd(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] r;
      m_u.start();
      tx({SLAVE_ADDR, 1'b0});
      tx(p);
      m_u.start();
      tx({SLAVE_ADDR, 1'b1});
      rx(1'b1, r);
      m_u.stop();
      chk(r, e);
   endtask : rd

   // Main sequence.
   initial begin
      logic [7:0] a, b;
      logic ack;
      sec_tick <= 1'b0;
      a1_match <= 1'b0;
      a2_match <= 1'b0;
      osc_stop <= 1'b0;
      bad_seen <= 1'b0;
      wv <= 4'h0;
      m_u.tick(12);
      sys_rst <= 1'b0;
      m_u.tick(10);
      rd(REG_CONTROL, CTRL_RESET);
      rd(REG_STATUS, 8'h80);
      $display("test reset done");
      for (int r = 0; r < 4; r++) begin
         wr(REG_CONTROL, 8'h20 | 8'(r << 3));
         wv <= 4'(1 << r);
         m_u.tick(4);
         chk({7'h0, pin}, 8'h01);
         wv <= ~4'(1 << r);
         m_u.tick(4);
         chk({7'h0, pin}, 8'h00);
      end
      m_u.start();
      m_u.xb(8'ha0, 1'b1, a, ack);
      chk({7'h0, ack}, 8'h01);
      m_u.xb(8'h0e, 1'b1, a, ack);
      chk({7'h0, ack}, 8'h01);
      m_u.stop();
      $display("test rates done");
      wr(REG_CONTROL, 8'hd8);
      rd(REG_CONTROL, 8'h98);
      chk({7'h0, run}, 8'h01);
      chk(8'(clr_n), 8'h01);
      wr(8'h05, 8'h12);
      chk(last_wa, 8'h05);
      chk(last_wd, 8'h12);
      rd(REG_CONTROL, 8'hb8);
      chk({7'h0, run}, 8'h00);
      rd(8'h03, 8'h43);
      m_u.start();
      tx({SLAVE_ADDR, 1'b1});
      rx(1'b1, a);
      m_u.stop();
      chk(a, 8'h44);
      m_u.start();
      tx({SLAVE_ADDR, 1'b0});
      tx(REG_CONTROL);
      tx(8'h00);
      tx(8'h00);
      m_u.start();
      tx({SLAVE_ADDR, 1'b0});
      tx(REG_CONTROL);
      m_u.start();
      tx({SLAVE_ADDR, 1'b1});
      rx(1'b0, a);
      rx(1'b1, b);
      m_u.stop();
      chk(a, 8'h00);
      chk(b, 8'h00);
      $display("test pointer done");
      a1_match <= 1'b1;
      m_u.tick(20);
      rd(REG_STATUS, 8'h00);
      sec_tick <= 1'b1;
      m_u.tick(1);
      sec_tick <= 1'b0;
      a1_match <= 1'b0;
      rd(REG_STATUS, 8'h01);
      wr(REG_CONTROL, 8'h05);
      chk({7'h0, pin}, 8'h00);
      wr(REG_STATUS, 8'h07);
      rd(REG_STATUS, 8'h01);
      wr(REG_CONTROL, 8'h04);
      chk({7'h0, pin}, 8'h01);
      wr(REG_STATUS, 8'h00);
      a2_match <= 1'b1;
      sec_tick <= 1'b1;
      m_u.tick(1);
      sec_tick <= 1'b0;
      a2_match <= 1'b0;
      wr(REG_CONTROL, 8'h06);
      chk({7'h0, pin}, 8'h00);
      wr(REG_CONTROL, 8'h02);
      chk({7'h0, alt_n}, 8'h00);
      bad_seen <= 1'b1;
      m_u.tick(1);
      bad_seen <= 1'b0;
      m_u.tick(4);
      chk({7'h0, alt_n}, 8'h01);
      rd(REG_STATUS, 8'h06);
      osc_stop <= 1'b1;
      m_u.tick(1);
      osc_stop <= 1'b0;
      rd(REG_STATUS, 8'h86);
      $display("test alarms done");
      close_out();
   end

   // A hung bus ends the run at about three times the expected length of about one millisecond.
   initial begin
      #(3_000_000);
      err_count++;
      $display("watchdog expired");
      close_out();
   end
endmodule : rtcci_top_test

// File: hdl/rtcci_flag.sv
// Sticky status flag: hardware sets it, software clears it, a set wins over a clear.
// Assumes set and clr are single-cycle terms from the same clock domain.
`timescale 1ns/100ps
module rtcci_flag #(
   parameter logic RESET_VAL = 1'b0
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic set,
   input wire logic clr,
   output logic q
);
   import rtcci_pkg::*;

   logic q_q;

   // Setting has priority so an event in the clearing cycle is not lost.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_q <= RESET_VAL;
      end else if (set) begin
         q_q <= 1'b1;
      end else if (clr) begin
         q_q <= 1'b0;
      end
   end

   assign q = q_q;

   a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
      set |=> q_q)
      else $error("Flag missed an event.");

   a_clear_works: assert property (@(posedge clk) disable iff (sys_rst)
      (clr && !set) |=> !q_q ##1 (!q_q || $past(set)))
      else $error("Flag did not clear or rose without an event.");

endmodule : rtcci_flag

// File: hdl/rtcci_pkg.sv
// Shared constants and types for the clock control/status block and its serial slave port.
// Assumes a single 10 MHz system clock and register byte addressing through the slave pointer.
package rtcci_pkg;

   // Data and counter widths.
   localparam int BYTE_W = 8;
   localparam int CNT_W = 4;

   // Seven-bit slave address, binary 1101000.
   localparam logic [6:0] SLAVE_ADDR = 7'h68;

   // Register offsets as seen through the register pointer.
   localparam logic [7:0] REG_CONTROL = 8'h0e;
   localparam logic [7:0] REG_STATUS = 8'h0f;
   localparam logic [7:0] CAL_LAST = 8'h06;

   // Control register field positions.
   localparam int CTRL_SPARE = 7;
   localparam int CTRL_HOLD = 5;
   localparam int CTRL_RATE_HI = 4;
   localparam int CTRL_RATE_LO = 3;
   localparam int CTRL_ROUTE = 2;
   localparam int CTRL_SECOND_ALARM_IRQ_ENABLE = 1;
   localparam int CTRL_FIRST_ALARM_IRQ_ENABLE = 0;

   // Status register field positions.
   localparam int STAT_OSC = 7;
   localparam int STAT_BAD = 2;
   localparam int STAT_A2 = 1;
   localparam int STAT_A1 = 0;

   // Values after reset and the writable bits of the control register.
   localparam logic [7:0] CTRL_RESET = 8'h38;
   localparam logic [7:0] CTRL_WR_MASK = 8'hbf;
   localparam logic OSC_FLAG_RESET = 1'b1;
   localparam logic PIN_IDLE = 1'b1;

   // Rate codes of the square-wave selector.
   localparam logic [1:0] RATE_1HZ = 2'h0;
   localparam logic [1:0] RATE_4096HZ = 2'h1;
   localparam logic [1:0] RATE_8192HZ = 2'h2;
   localparam logic [1:0] RATE_32KHZ = 2'h3;

   // Bits per byte on the serial bus, counted by rising clock edges.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Bus timing against the system clock; fast mode leaves the fewest samples.
   localparam int CLK_HZ = 10000000;
   localparam int STD_SCL_HZ = 100000;
   localparam int FAST_SCL_HZ = 400000;
   localparam int FAST_SCL_PERIOD_CYC = CLK_HZ / FAST_SCL_HZ;
   localparam int STD_SCL_PERIOD_CYC = CLK_HZ / STD_SCL_HZ;

   // States of the serial slave.
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_PTR = 3'h2,
      ST_WDATA = 3'h3,
      ST_ACK = 3'h4,
      ST_RDATA = 3'h5,
      ST_RACK = 3'h6,
      ST_IGNORE = 3'h7
   } rtcci_state_e;

endpackage : rtcci_pkg

// File: hdl/rtcci_sync.sv
// Three-stage input synchroniser with a two-sample agreement filter.
// Assumes the input is asynchronous to clk and idles at the IDLE_VAL level.
`timescale 1ns/100ps
module rtcci_sync #(
   parameter logic IDLE_VAL = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pin,
   output logic q
);
   import rtcci_pkg::*;

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic q_q;

   // The first stage feeds only the second; the filter compares stages two and three.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_q <= IDLE_VAL;
         s2_q <= IDLE_VAL;
         s3_q <= IDLE_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once two later samples agree, which rejects one-cycle spikes.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_q <= IDLE_VAL;
      end else if (s2_q == s3_q) begin
         q_q <= s2_q;
      end
   end

   assign q = q_q;

   a_filter_hold: assert property (@(posedge clk) disable iff (sys_rst)
      (s2_q != s3_q) |=> (q_q == $past(q_q)))
      else $error("Filtered input moved while samples disagreed.");

endmodule : rtcci_sync

// File: hdl/rtcci_top.sv
// Control and status registers of a serial clock/calendar with their two-wire slave port.
// Assumes calendar, alarm comparators and wave dividers sit outside on the same clock.
`timescale 1ns/100ps
module rtcci_top (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic scl_pin,
   input wire logic sda_pin,
   output logic sda_out,
   output logic sda_oe,
   input wire logic sec_tick,
   input wire logic first_alarm_match,
   input wire logic second_alarm_match,
   input wire logic osc_stopped,
   input wire logic bad_value_seen,
   input wire logic wave_1hz,
   input wire logic wave_4096hz,
   input wire logic wave_8192hz,
   input wire logic wave_32khz,
   input wire logic [rtcci_pkg::BYTE_W-1:0] cal_rd_data,
   output logic [rtcci_pkg::BYTE_W-1:0] cal_rd_addr,
   output logic cal_wr_stb,
   output logic [rtcci_pkg::BYTE_W-1:0] cal_wr_addr,
   output logic [rtcci_pkg::BYTE_W-1:0] cal_wr_data,
   output logic cal_run,
   output logic cal_clear,
   output logic wave_or_irq_pin,
   output logic alternate_irq_pin_n
);
   import rtcci_pkg::*;

   logic scl_f;
   logic sda_f;
   logic scl_p_q;
   logic sda_p_q;
   rtcci_state_e state_q, state_d;
   rtcci_state_e ack_next_q, ack_next_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [BYTE_W-1:0] shift_q, shift_d;
   logic [BYTE_W-1:0] ptr_q, ptr_d;
   logic oe_q, oe_d;
   logic mack_q, mack_d;
   logic [BYTE_W-1:0] ctrl_q;
   logic cal_wr_stb_q;
   logic [BYTE_W-1:0] cal_wr_addr_q;
   logic [BYTE_W-1:0] cal_wr_data_q;
   logic cal_run_q;
   logic cal_clear_q;
   logic pin_q;
   logic alt_q;
   logic sda_out_q;
   logic osc_f;
   logic bad_f;
   logic a2_f;
   logic a1_f;

   // Both bus lines are asynchronous to clk and pass the filtered synchroniser.
   rtcci_sync #(.IDLE_VAL(PIN_IDLE)) u_scl_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(scl_pin),
      .q(scl_f)
   );
   rtcci_sync #(.IDLE_VAL(PIN_IDLE)) u_sda_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(sda_pin),
      .q(sda_f)
   );

   // Previous filtered levels for edge and condition detection.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         scl_p_q <= PIN_IDLE;
         sda_p_q <= PIN_IDLE;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   // Bus events; start and stop need the clock high in both samples.
   wire scl_rise = scl_f && !scl_p_q;
   wire scl_fall = !scl_f && scl_p_q;
   wire bus_start = scl_f && scl_p_q && sda_p_q && !sda_f;
   wire bus_stop = scl_f && scl_p_q && !sda_p_q && sda_f;
   wire byte_done = (cnt_q == BITS_PER_BYTE);
   wire addr_hit = (shift_q[7:1] == SLAVE_ADDR);

   // Register decode and read selection.
   wire is_ctrl = (ptr_q == REG_CONTROL);
   wire is_stat = (ptr_q == REG_STATUS);
   wire byte_wr = scl_fall && byte_done && (state_q == ST_WDATA);
   wire ctrl_wr = byte_wr && is_ctrl;
   wire stat_wr = byte_wr && is_stat;
   wire cal_time_wr = byte_wr && (ptr_q <= CAL_LAST);
   wire [BYTE_W-1:0] stat_rd = {osc_f, 4'h0, bad_f, a2_f, a1_f};
   wire [BYTE_W-1:0] rd_byte = is_ctrl ? ctrl_q : (is_stat ? stat_rd : cal_rd_data);
   wire rd_load = scl_fall && (((state_q == ST_ACK) && (ack_next_q == ST_RDATA))
                  || ((state_q == ST_RACK) && mack_q));

   // Slave sequencer; start and stop override whatever byte is in flight.
   always_comb begin
      state_d = state_q;
      ack_next_d = ack_next_q;
      cnt_d = cnt_q;
      shift_d = shift_q;
      ptr_d = ptr_q;
      oe_d = oe_q;
      mack_d = mack_q;
      if (bus_start) begin
         state_d = ST_ADDR;
         cnt_d = '0;
         oe_d = 1'b0;
      end else if (bus_stop) begin
         state_d = ST_IDLE;
         oe_d = 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE, ST_IGNORE: begin
               // Released until the next start condition.
               oe_d = 1'b0;
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (scl_rise) begin
                  shift_d = {shift_q[6:0], sda_f};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && byte_done) begin
                  cnt_d = '0;
                  oe_d = 1'b1;
                  state_d = ST_ACK;
                  if (state_q == ST_ADDR) begin
                     if (addr_hit) begin
                        ack_next_d = shift_q[0] ? ST_RDATA : ST_PTR;
                     end else begin
                        oe_d = 1'b0;
                        state_d = ST_IGNORE;
                     end
                  end else begin
                     ack_next_d = ST_WDATA;
                     ptr_d = (state_q == ST_PTR) ? shift_q : ptr_q + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall && (ack_next_q != ST_RDATA)) begin
                  oe_d = 1'b0;
                  state_d = ack_next_q;
               end
            end
            ST_RDATA: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (byte_done) begin
                     oe_d = 1'b0;
                     state_d = ST_RACK;
                  end else begin
                     shift_d = {shift_q[6:0], 1'b0};
                     oe_d = !shift_q[6];
                  end
               end
            end
            ST_RACK: begin
               if (scl_rise) begin
                  mack_d = !sda_f;
               end else if (scl_fall && !mack_q) begin
                  state_d = ST_IGNORE;
               end
            end
         endcase
         // Loading the next read byte drives its first bit while the clock is low.
         if (rd_load) begin
            shift_d = rd_byte;
            ptr_d = ptr_q + 8'h01;
            oe_d = !rd_byte[7];
            cnt_d = '0;
            state_d = ST_RDATA;
         end
      end
   end

   // Sequencer registers; the pointer keeps its value across transfers.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
         ack_next_q <= ST_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         ptr_q <= '0;
         oe_q <= 1'b0;
         mack_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ack_next_q <= ack_next_d;
         cnt_q <= cnt_d;
         shift_q <= shift_d;
         ptr_q <= ptr_d;
         oe_q <= oe_d;
         mack_q <= mack_d;
      end
   end

   // Control register; the unused bit is masked off on every write.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl_q <= shift_q & CTRL_WR_MASK;
      end else if (cal_time_wr) begin
         ctrl_q[CTRL_HOLD] <= 1'b1;
      end
   end

   // Calendar-side strobes; the clear pulse marks a write that releases the hold.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cal_wr_stb_q <= 1'b0;
         cal_wr_addr_q <= '0;
         cal_wr_data_q <= '0;
         cal_clear_q <= 1'b0;
         cal_run_q <= 1'b0;
      end else begin
         cal_wr_stb_q <= byte_wr && !is_ctrl && !is_stat;
         cal_wr_addr_q <= ptr_q;
         cal_wr_data_q <= shift_q;
         cal_clear_q <= ctrl_wr && ctrl_q[CTRL_HOLD] && !shift_q[CTRL_HOLD];
         cal_run_q <= !ctrl_q[CTRL_HOLD];
      end
   end

   // Status flags; writing one leaves a flag alone, writing zero clears it.
   rtcci_flag #(.RESET_VAL(OSC_FLAG_RESET)) u_osc_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .set(osc_stopped),
      .clr(stat_wr && !shift_q[STAT_OSC]),
      .q(osc_f)
   );
   rtcci_flag #(.RESET_VAL(1'b0)) u_bad_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .set(bad_value_seen),
      .clr(stat_wr && !shift_q[STAT_BAD]),
      .q(bad_f)
   );
   rtcci_flag #(.RESET_VAL(1'b0)) u_a2_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .set(sec_tick && second_alarm_match),
      .clr(stat_wr && !shift_q[STAT_A2]),
      .q(a2_f)
   );
   rtcci_flag #(.RESET_VAL(1'b0)) u_a1_flag (
      .clk(clk),
      .sys_rst(sys_rst),
      .set(sec_tick && first_alarm_match),
      .clr(stat_wr && !shift_q[STAT_A1]),
      .q(a1_f)
   );

   // Pin selection; interrupts are active low and a bad time value silences them.
   wire [1:0] rate = ctrl_q[CTRL_RATE_HI:CTRL_RATE_LO];
   wire route = ctrl_q[CTRL_ROUTE];
   wire wave_sel = (rate == RATE_1HZ) ? wave_1hz :
                   (rate == RATE_4096HZ) ? wave_4096hz :
                   (rate == RATE_8192HZ) ? wave_8192hz : wave_32khz;
   wire irq_n = bad_f ? 1'b1 :
                ctrl_q[CTRL_FIRST_ALARM_IRQ_ENABLE] ? !a1_f :
                ctrl_q[CTRL_SECOND_ALARM_IRQ_ENABLE] ? !a2_f : 1'b1;
   wire pin_d = route ? irq_n : wave_sel;
   wire alt_d = !(!route && ctrl_q[CTRL_SECOND_ALARM_IRQ_ENABLE] && a2_f && !bad_f);

   // Output flops; the data line only ever pulls low, so its level is a fixed zero.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_q <= PIN_IDLE;
         alt_q <= PIN_IDLE;
         sda_out_q <= 1'b0;
      end else begin
         pin_q <= pin_d;
         alt_q <= alt_d;
         sda_out_q <= 1'b0;
      end
   end

   assign sda_out = sda_out_q;
   assign sda_oe = oe_q;
   assign cal_rd_addr = ptr_q;
   assign cal_wr_stb = cal_wr_stb_q;
   assign cal_wr_addr = cal_wr_addr_q;
   assign cal_wr_data = cal_wr_data_q;
   assign cal_run = cal_run_q;
   assign cal_clear = cal_clear_q;
   assign wave_or_irq_pin = pin_q;
   assign alternate_irq_pin_n = alt_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_start;
      scl_f && scl_p_q && sda_p_q && !sda_f;
   endsequence
   sequence s_release;
      ctrl_wr && ctrl_q[CTRL_HOLD] && !shift_q[CTRL_HOLD];
   endsequence

   a_start_addr: assert property (s_start |=> (state_q == ST_ADDR) && !oe_q)
      else $error("Start did not open an address phase.");
   a_stop_idle: assert property (bus_stop |=> (state_q == ST_IDLE) && !oe_q)
      else $error("Stop did not release the bus.");
   a_ack_low: assert property ((state_q == ST_ACK) |-> oe_q)
      else $error("Acknowledge not driven low.");
   a_foreign_quiet: assert property ((state_q == ST_IGNORE) |-> !oe_q)
      else $error("Data line driven while ignoring.");
   a_addr_reject: assert property ((state_q == ST_ADDR) && scl_fall && byte_done && !addr_hit
      |=> (state_q == ST_IGNORE))
      else $error("Foreign address was acknowledged.");
   a_ptr_step: assert property (cal_wr_stb_q |-> (ptr_q == cal_wr_addr_q + 8'h01))
      else $error("Pointer did not step after a write.");
   a_hold_on_cal: assert property (cal_time_wr |=> ctrl_q[CTRL_HOLD] ##1 !cal_run_q)
      else $error("Calendar write did not set hold.");
   a_restart_run: assert property (s_release |=> cal_clear_q ##1 (!cal_clear_q && cal_run_q))
      else $error("Releasing hold did not clear and restart.");
   a_wave_route: assert property (!route |=> (wave_or_irq_pin == $past(wave_sel)))
      else $error("Square wave not on the pin.");
   a_reset_ctrl: assert property ($past(sys_rst) |-> (ctrl_q == CTRL_RESET) && osc_f)
      else $error("Control or halt flag wrong after reset.");
   a_irq_first: assert property (route && ctrl_q[CTRL_FIRST_ALARM_IRQ_ENABLE] && a1_f && !bad_f
      |=> !wave_or_irq_pin)
      else $error("First alarm did not pull the pin.");
   a_irq_second: assert property (route && !ctrl_q[CTRL_FIRST_ALARM_IRQ_ENABLE] && ctrl_q[CTRL_SECOND_ALARM_IRQ_ENABLE] && a2_f
      && !bad_f |=> !wave_or_irq_pin)
      else $error("Second alarm did not pull the pin.");
   a_irq_masked: assert property (route && !ctrl_q[CTRL_FIRST_ALARM_IRQ_ENABLE] && !ctrl_q[CTRL_SECOND_ALARM_IRQ_ENABLE]
      |=> wave_or_irq_pin)
      else $error("Disabled alarm reached the pin.");
   a_bad_blocks: assert property (route && bad_f |=> wave_or_irq_pin)
      else $error("Pin triggered with a bad time value.");
   a_alt_pin: assert property (!route && ctrl_q[CTRL_SECOND_ALARM_IRQ_ENABLE] && a2_f && !bad_f
      |=> !alternate_irq_pin_n)
      else $error("Second alarm missing on the alternate pin.");
   a_tick_only: assert property (($rose(a1_f) || $rose(a2_f)) |-> $past(sec_tick))
      else $error("Alarm flag set off the second update.");
   a_osc_sticky: assert property (osc_f && !(stat_wr && !shift_q[STAT_OSC]) |=> osc_f)
      else $error("Halt flag dropped without a clear.");
   a_spare_kept: assert property (ctrl_wr |=> (ctrl_q[CTRL_SPARE] == $past(shift_q[CTRL_SPARE]))
      && !ctrl_q[6])
      else $error("Spare or unused control bit wrong.");
   a_master_nack: assert property ((state_q == ST_RACK) && scl_fall && !mack_q
      |=> (state_q == ST_IGNORE) && !oe_q)
      else $error("Read went on after not-acknowledge.");
   a_read_load: assert property (rd_load |=> (oe_q == !$past(rd_byte[7])))
      else $error("Read byte first bit not driven.");

endmodule : rtcci_top
